// *** hw/media_select.v ***
// Operation
// - Watch fiber and copper, follow attached medium
// - First medium to link wins, other powers down
// - Link lost: power both, search again
// - Signal detect gates fiber serializer power
// - Selectable signal detect polarity
// - Drop non-preferred link four seconds
// - Preference field: first, fiber, copper
// - Separate copper and fiber energy status
// - Sticky flag per medium on energy change
// - Fiber preferred and linked: copper energy reads 1
// - Copper preferred: fiber energy from detect
// - 1000BASE-X link up and down conditions
// - SGMII negotiated link needs word bit 15
// - Page register selects copper, fiber, MAC
// - Settings except polarity apply only after software reset
// - One shared link-up bit in both pages
// - One shared media-type bit in both pages
// - Other status bits stored per medium
// - Status summarizes speed, duplex, pause
// - Auto page bit loads page on link
// - Fiber mode 011 is 1000BASE-X, 010 SGMII
// - SGMII word bit 15 one means link up
`include "media_select_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module media_select #(
    parameter DROP_CYCLES = `DROP_CYC,
    parameter DROP_W      = 28,
    parameter COMMA_CYC   = `COMMA_LOSS_CYC,
    parameter COMMA_W     = 10
) (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        copper_energy,
    input  wire        copper_link_ok,
    input  wire [1:0]  copper_speed,
    input  wire        copper_duplex,
    input  wire [1:0]  copper_pause,
    input  wire        fiber_signal_detect,
    input  wire        fiber_comma_seen,
    input  wire        fiber_an_complete,
    input  wire        fiber_an_restart,
    input  wire [15:0] fiber_rx_word,
    input  wire        fiber_duplex,
    input  wire [1:0]  fiber_pause,
    output wire        copper_power_up,
    output wire        fiber_power_up,
    output wire        copper_enable,
    output wire        fiber_enable,
    output wire        link_up,
    output wire        media_is_fiber
);

    // One-hot selector states
    localparam [3:0] ST_SEARCH = 4'h1;
    localparam [3:0] ST_COPPER = 4'h2;
    localparam [3:0] ST_FIBER  = 4'h4;
    localparam [3:0] ST_DROP   = 4'h8;

    // Last counts kept as integers, then cut to counter width on purpose
    localparam integer       DROP_LAST_I  = DROP_CYCLES - 1;
    localparam integer       COMMA_LAST_I = COMMA_CYC - 1;
    localparam [DROP_W-1:0]  DROP_LAST    = DROP_LAST_I[DROP_W-1:0];
    localparam [COMMA_W-1:0] COMMA_LAST   = COMMA_LAST_I[COMMA_W-1:0];

    // Page decode shared by status and change reads
    function [1:0] page_sel;
        input [7:0] pg;
        begin
            if (pg == `PAGE_COPPER)
                page_sel = 2'd0;
            else if (pg == `PAGE_FIBER)
                page_sel = 2'd1;
            else if (pg == `PAGE_MAC)
                page_sel = 2'd2;
            else
                page_sel = 2'd3;
        end
    endfunction

    reg  [3:0]         state_reg;
    reg  [3:0]         state_next;
    reg  [15:0]        page_reg;
    reg  [1:0]         pref_pend_reg;
    reg  [2:0]         mode_pend_reg;
    reg                anen_pend_reg;
    reg  [1:0]         pref_reg;
    reg  [2:0]         mode_reg;
    reg                anen_reg;
    reg                pol_reg;
    reg                drop_copper_reg;
    reg  [DROP_W-1:0]  drop_cnt_reg;
    reg  [COMMA_W-1:0] comma_cnt_reg;
    reg                comma_ok_reg;
    reg                cu_seen_prev_reg;
    reg                fi_seen_prev_reg;
    reg                cu_chg_reg;
    reg                fi_chg_reg;
    reg  [15:0]        cu_stat_reg;
    reg  [15:0]        fi_stat_reg;

    // Bus decode; no wait states, so access is a single cycle
    // Writes act at the access edge only
    wire       setup  = psel & ~penable;
    wire       access = psel & penable;
    wire       wr     = access & pwrite;
    wire       mapped = (paddr == `OFF_PAGE) | (paddr == `OFF_CTRL) |
                        (paddr == `OFF_STAT) | (paddr == `OFF_CHG);
    wire       wr_page = wr & (paddr == `OFF_PAGE);
    wire       wr_ctrl = wr & (paddr == `OFF_CTRL);
    wire       wr_chg  = wr & (paddr == `OFF_CHG);
    wire       soft_rst = wr_ctrl & pwdata[`C_SRST];
    wire [1:0] psel_pg  = page_sel(page_reg[`PAGE_NUM]);

    // Zero wait states; unmapped offsets answer with an error
    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    // Detect polarity applied before anything else looks at it
    wire sd = fiber_signal_detect ^ pol_reg;

    wire sgmii = (mode_reg == `MODE_SGMII);

    // Fiber link per active mode and negotiation setting
    wire fi_an_ok = sgmii ? (fiber_an_complete & fiber_rx_word[`SG_LINK])
                          : fiber_an_complete;
    wire fiber_link = sd & comma_ok_reg & ~fiber_an_restart &
                      (anen_reg ? fi_an_ok : 1'b1);
    wire copper_link = copper_link_ok;

    wire in_search = state_reg[0];
    wire in_copper = state_reg[1];
    wire in_fiber  = state_reg[2];
    wire in_drop   = state_reg[3];
    wire drop_done = (drop_cnt_reg == DROP_LAST);

    // Copper energy is ignored once the preferred fiber link holds
    wire cu_seen = (in_fiber & (pref_reg == `PREF_FIBER)) ? 1'b0
                                                          : copper_energy;
    wire fi_seen = sd;

    // Counter stops at its last count until a comma returns,
    // so a long gap cannot wrap and fake a fresh comma window.
    // Window length is a parameter; default is ten microseconds
    // Comma loss window: link falls after a sustained gap
    always @(posedge ref_clk) begin
        if (rst) begin
            comma_cnt_reg <= {COMMA_W{1'b0}};
            comma_ok_reg  <= 1'b0;
        end else if (fiber_comma_seen) begin
            comma_cnt_reg <= {COMMA_W{1'b0}};
            comma_ok_reg  <= 1'b1;
        end else if (comma_cnt_reg == COMMA_LAST) begin
            comma_ok_reg  <= 1'b0;
        end else begin
            comma_cnt_reg <= comma_cnt_reg + 1'b1;
        end
    end

    // Only one medium is ever enabled: the states are exclusive.
    // Preference acts once a medium already holds link, and on a tie;
    // while searching, an earlier link wins regardless of preference
    // Medium selection
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_SEARCH: begin
                // Both searching; first link wins, a tie goes to fiber if preferred, else copper
                if (copper_link & fiber_link)
                    state_next = (pref_reg == `PREF_FIBER) ? ST_FIBER
                                                           : ST_COPPER;
                else if (copper_link)
                    state_next = ST_COPPER;
                else if (fiber_link)
                    state_next = ST_FIBER;
            end
            ST_COPPER: begin
                if (!copper_link)
                    state_next = ST_SEARCH;
                else if (pref_reg == `PREF_FIBER && fi_seen)
                    state_next = ST_DROP;
            end
            ST_FIBER: begin
                if (!fiber_link)
                    state_next = ST_SEARCH;
                else if (pref_reg == `PREF_COPPER && cu_seen)
                    state_next = ST_DROP;
            end
            ST_DROP: begin
                // Preferred medium alone gets its chance
                if (drop_copper_reg & copper_link)
                    state_next = ST_COPPER;
                else if (!drop_copper_reg & fiber_link)
                    state_next = ST_FIBER;
                else if (drop_done)
                    state_next = ST_SEARCH;
            end
            default: state_next = ST_SEARCH;
        endcase
    end

    // Software reset restarts the search with the new settings.
    // Drop timer restarts on every entry, never resumes midway;
    // four seconds at the reference clock needs a wide counter
    // State, drop timer and which medium the drop favours
    always @(posedge ref_clk) begin
        if (rst | soft_rst) begin
            state_reg       <= ST_SEARCH;
            drop_cnt_reg    <= {DROP_W{1'b0}};
            drop_copper_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_next == ST_DROP && !in_drop) begin
                drop_cnt_reg    <= {DROP_W{1'b0}};
                drop_copper_reg <= in_fiber;
            end else if (in_drop && !drop_done) begin
                drop_cnt_reg <= drop_cnt_reg + 1'b1;
            end
        end
    end

    // Powering down the idle medium saves power but also blinds it:
    // only energy still seen (copper line, fiber detect) can wake
    // the preference logic, which is why detect gates the serializer
    // Power: the idle medium sleeps; serializer also needs detect
    assign copper_power_up = in_search | in_copper |
                             (in_drop & drop_copper_reg);
    assign fiber_power_up  = sd & (in_search | in_fiber |
                             (in_drop & ~drop_copper_reg));
    assign copper_enable   = in_copper;
    assign fiber_enable    = in_fiber;
    assign link_up         = in_copper | in_fiber;
    assign media_is_fiber  = in_fiber;

    // Pending copies are what software reads back, so a setting
    // written without reset is visible but not yet in force.
    // Polarity is the exception: it acts at once
    // Control: pending settings wait for a software reset
    always @(posedge ref_clk) begin
        if (rst) begin
            pref_pend_reg <= `PREF_RST;
            mode_pend_reg <= `MODE_RST;
            anen_pend_reg <= `ANEN_RST;
            pref_reg      <= `PREF_RST;
            mode_reg      <= `MODE_RST;
            anen_reg      <= `ANEN_RST;
            pol_reg       <= `POL_RST;
        end else if (wr_ctrl) begin
            pref_pend_reg <= pwdata[`C_PREF];
            mode_pend_reg <= pwdata[`C_MODE];
            anen_pend_reg <= pwdata[`C_ANEN];
            pol_reg       <= pwdata[`C_POL];
            if (pwdata[`C_SRST]) begin
                pref_reg <= pwdata[`C_PREF];
                mode_reg <= pwdata[`C_MODE];
                anen_reg <= pwdata[`C_ANEN];
            end
        end
    end

    // Auto load beats a same-cycle page write, so software that
    // races a link change may find its page overwritten.
    // Only the page number moves; the auto bit itself stays
    // Page: auto bit reloads it on entering a link state
    always @(posedge ref_clk) begin
        if (rst) begin
            page_reg <= `PAGE_RST;
        end else if (page_reg[`PAGE_AUTO] && state_next == ST_COPPER && !in_copper) begin
            page_reg[`PAGE_NUM] <= `PAGE_COPPER;
        end else if (page_reg[`PAGE_AUTO] && state_next == ST_FIBER && !in_fiber) begin
            page_reg[`PAGE_NUM] <= `PAGE_FIBER;
        end else if (wr_page) begin
            page_reg <= pwdata[15:0];
        end
    end

    // Previous values reset to the idle level of the inputs,
    // so no false change is flagged right after reset
    // Energy change flags; a new change beats a clear
    always @(posedge ref_clk) begin
        if (rst) begin
            cu_seen_prev_reg <= 1'b0;
            fi_seen_prev_reg <= 1'b0;
            cu_chg_reg       <= 1'b0;
            fi_chg_reg       <= 1'b0;
        end else begin
            cu_seen_prev_reg <= cu_seen;
            fi_seen_prev_reg <= fi_seen;
            if (cu_seen != cu_seen_prev_reg)
                cu_chg_reg <= 1'b1;
            else if (wr_chg && psel_pg == 2'd0 && pwdata[`CHG_BIT])
                cu_chg_reg <= 1'b0;
            if (fi_seen != fi_seen_prev_reg)
                fi_chg_reg <= 1'b1;
            else if (wr_chg && psel_pg == 2'd1 && pwdata[`CHG_BIT])
                fi_chg_reg <= 1'b0;
        end
    end

    // Registered once a cycle; reads see results one cycle late,
    // which is harmless for software polling
    // Per-medium status storage; only link and media bits shared
    always @(posedge ref_clk) begin
        if (rst) begin
            cu_stat_reg <= 16'h0000;
            fi_stat_reg <= 16'h0000;
        end else begin
            cu_stat_reg           <= 16'h0000;
            cu_stat_reg[`S_SPEED]  <= copper_speed;
            cu_stat_reg[`S_DUPLEX] <= copper_duplex;
            cu_stat_reg[`S_PAUSE]  <= copper_pause;
            cu_stat_reg[`S_ENERGY] <= ~cu_seen;
            fi_stat_reg           <= 16'h0000;
            fi_stat_reg[`S_SPEED]  <= sgmii ? fiber_rx_word[`SG_SPEED]
                                            : `SPEED_1000;
            fi_stat_reg[`S_DUPLEX] <= sgmii ? fiber_rx_word[`SG_DUPLEX]
                                            : fiber_duplex;
            fi_stat_reg[`S_PAUSE]  <= fiber_pause;
            fi_stat_reg[`S_ENERGY] <= ~fi_seen;
        end
    end

    // Read data of the selected page, captured in the setup cycle
    reg [15:0] rd_val;
    always @* begin
        rd_val = 16'h0000;
        if (paddr == `OFF_PAGE) begin
            rd_val = page_reg;
        end else if (paddr == `OFF_CTRL) begin
            rd_val[`C_PREF] = pref_pend_reg;
            rd_val[`C_MODE] = mode_pend_reg;
            rd_val[`C_POL]  = pol_reg;
            rd_val[`C_ANEN] = anen_pend_reg;
        end else if (paddr == `OFF_STAT) begin
            case (psel_pg)
                2'd0: rd_val = cu_stat_reg;
                2'd1: rd_val = fi_stat_reg;
                2'd2: rd_val = {12'h000, state_reg};
                default: rd_val = 16'h0000;
            endcase
            if (psel_pg[1] == 1'b0) begin
                rd_val[`S_LINK]  = link_up;
                rd_val[`S_MEDIA] = media_is_fiber;
            end
        end else if (paddr == `OFF_CHG) begin
            if (psel_pg == 2'd0)
                rd_val[`CHG_BIT] = cu_chg_reg;
            else if (psel_pg == 2'd1)
                rd_val[`CHG_BIT] = fi_chg_reg;
        end
    end

    // Read data held until the next read setup
    always @(posedge ref_clk) begin
        if (rst)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata <= {16'h0000, rd_val};
    end

endmodule // media_select

`default_nettype wire

// *** hw/media_select_defines.vh ***
`ifndef MEDIA_SELECT_DEFINES_VH
`define MEDIA_SELECT_DEFINES_VH

// Clock and timing
`define CLK_PERIOD_NS  20
`define CLK_KHZ        50000
`define DROP_TIME_MS   4000
`define DROP_CYC       (`DROP_TIME_MS * `CLK_KHZ)
`define COMMA_LOSS_NS  10000
`define COMMA_LOSS_CYC (`COMMA_LOSS_NS / `CLK_PERIOD_NS)

// Register byte offsets
`define OFF_PAGE   8'h00
`define OFF_CTRL   8'h04
`define OFF_STAT   8'h08
`define OFF_CHG    8'h0c

// Page values
`define PAGE_COPPER 8'h00
`define PAGE_FIBER  8'h01
`define PAGE_MAC    8'h02
`define PAGE_AUTO   15
`define PAGE_NUM    7:0
`define PAGE_RST    16'h8000

// Control register fields
`define C_PREF 1:0
`define C_MODE 4:2
`define C_POL  5
`define C_ANEN 6
`define C_SRST 15

// Preferred media and fiber mode encodings
`define PREF_FIRST  2'b00
`define PREF_FIBER  2'b01
`define PREF_COPPER 2'b10
`define MODE_X      3'b011
`define MODE_SGMII  3'b010

// Control reset values
`define PREF_RST 2'b00
`define MODE_RST 3'b011
`define POL_RST  1'b0
`define ANEN_RST 1'b1

// Status fields
`define S_LINK   3
`define S_ENERGY 4
`define S_MEDIA  7
`define S_PAUSE  9:8
`define S_DUPLEX 13
`define S_SPEED  15:14
`define CHG_BIT  4

// Received SGMII word fields
`define SG_LINK   15
`define SG_DUPLEX 12
`define SG_SPEED  11:10
`define SPEED_1000 2'b10

`endif

// *** test/media_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module media_partner #(
    parameter int CU_DLY = 8,
    parameter int FI_DLY = 8
) (
    input  wire logic        ref_clk,
    input  wire logic        cu_plug,
    input  wire logic        fi_plug,
    input  wire logic        pol,
    input  wire logic        restart,
    input  wire logic        sg_link,
    input  wire logic [4:0]  res,
    input  wire logic        copper_power_up,
    input  wire logic        fiber_power_up,
    output logic             copper_energy,
    output logic             copper_link_ok,
    output logic [1:0]       copper_speed,
    output logic             copper_duplex,
    output logic [1:0]       copper_pause,
    output logic             fiber_signal_detect,
    output logic             fiber_comma_seen,
    output logic             fiber_an_complete,
    output logic             fiber_an_restart,
    output logic [15:0]      fiber_rx_word,
    output logic             fiber_duplex,
    output logic [1:0]       fiber_pause
);
    logic [7:0] cu_cnt = 8'h00;
    logic [7:0] fi_cnt = 8'h00;
    // Partners train only while powered; power loss restarts training
    always @(posedge ref_clk) begin
        cu_cnt <= (cu_plug && copper_power_up) ? cu_cnt + 8'(cu_cnt != CU_DLY) : 8'h00;
        fi_cnt <= (fi_plug && fiber_power_up) ? fi_cnt + 8'(fi_cnt != FI_DLY) : 8'h00;
    end
    assign copper_energy       = cu_plug;
    assign copper_link_ok      = cu_cnt == CU_DLY;
    assign copper_speed        = res[4:3];
    assign copper_duplex       = res[2];
    assign copper_pause        = res[1:0];
    // Optics detect follows the cable, never held active
    assign fiber_signal_detect = fi_plug ^ pol;
    assign fiber_comma_seen    = fi_plug && fiber_power_up;
    assign fiber_an_complete   = fi_cnt == FI_DLY;
    assign fiber_an_restart    = restart;
    // Unpowered serializer sees no word, only the inverse
    assign fiber_rx_word       = {sg_link, 15'h0801} ^ {16{!fiber_power_up}};
    assign fiber_duplex        = res[2];
    assign fiber_pause         = res[1:0];
endmodule // media_partner
`default_nettype wire

// *** test/media_select_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module media_select_assertions (
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        copper_link_ok,
    input wire logic        fiber_signal_detect,
    input wire logic        copper_power_up,
    input wire logic        fiber_power_up,
    input wire logic        copper_enable,
    input wire logic        fiber_enable,
    input wire logic        link_up,
    input wire logic        media_is_fiber
);
    logic pol;
    // Detect polarity acts at once, so mirror it
    always @(posedge ref_clk) begin
        if (rst)
            pol <= 1'b0;
        else if (psel && penable && pwrite && paddr == 8'h04)
            pol <= pwdata[5];
    end
    wire det = fiber_signal_detect ^ pol;
    wire wr  = psel && pwrite;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_drop;
        $fell(copper_enable) && !copper_power_up;
    endsequence
    sequence s_back;
        (!copper_power_up)[*8] ##[1:1000] (copper_power_up || fiber_enable);
    endsequence
    chk_bad_addr: assert property (psel && penable |-> pready &&
        pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c})) else $error("bad pslverr");
    chk_one_medium: assert property (!(copper_enable && fiber_enable))
        else $error("both media on");
    chk_copper_shared: assert property (copper_enable |-> link_up && !media_is_fiber)
        else $error("copper link status wrong");
    chk_fiber_shared: assert property (fiber_enable |-> link_up && media_is_fiber)
        else $error("fiber link status wrong");
    chk_serdes_gate: assert property (fiber_power_up |-> det)
        else $error("serializer on without detect");
    chk_idle_off: assert property ((copper_enable |-> !fiber_power_up) and
        (fiber_enable |-> !copper_power_up)) else $error("idle medium powered");
    chk_copper_link: assert property (!link_up && copper_power_up && copper_link_ok
        && !det && !wr |=> copper_enable) else $error("copper link missed");
    chk_copper_loss: assert property (copper_enable && !copper_link_ok && !det && !wr
        |=> !link_up && copper_power_up) else $error("no search after loss");
    chk_drop_time: assert property (s_drop |-> s_back)
        else $error("drop length wrong");
endmodule // media_select_assertions
bind media_select media_select_assertions i_media_select_assertions (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .copper_link_ok(copper_link_ok), .fiber_signal_detect(fiber_signal_detect),
    .copper_power_up(copper_power_up), .fiber_power_up(fiber_power_up),
    .copper_enable(copper_enable), .fiber_enable(fiber_enable), .link_up(link_up),
    .media_is_fiber(media_is_fiber));
`default_nettype wire

// *** test/media_select_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module media_select_tb;
    localparam int DROP = 50;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, m;
    logic cu_plug = 0, fi_plug = 0, pol = 0, restart = 0, sg_link = 0;
    logic [4:0] res = 5'h00;
    logic [32:0] e, exp_q[$];
    logic [31:0] msk_q[$];
    int fails = 0, cmp_count = 0, seed = 32'h83c10e0f, n;
    wire [31:0] prdata;
    wire pready, pslverr, copper_energy, copper_link_ok, copper_duplex, fiber_signal_detect;
    wire fiber_comma_seen, fiber_an_complete, fiber_an_restart, fiber_duplex;
    wire copper_power_up, fiber_power_up, copper_enable, fiber_enable, link_up, media_is_fiber;
    wire [1:0] copper_speed, copper_pause, fiber_pause;
    wire [15:0] fiber_rx_word;
    media_select #(.DROP_CYCLES(DROP), .COMMA_CYC(8)) i_media_select (.*);
    media_partner i_media_partner (.*);
    initial forever #10 ref_clk = ~ref_clk;
    // Read answers are compared where the slave gives them
    always @(posedge ref_clk) begin
        if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            `CHK("read", e & {1'b1, m}, {pslverr, prdata} & {1'b1, m})
        end
    end
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic bail;
        fails++;
        tally_and_finish();
    endtask
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [32:0] x = 33'h0, input logic [31:0] k = 32'hffffffff);
        int i;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        if (!w) begin
            exp_q.push_back(x);
            msk_q.push_back(k);
        end
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge ref_clk);
        if (i == 20) bail();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Bounded wait on copper, fiber or copper power
    task automatic await(input int s, input logic v);
        int i;
        for (i = 0; i < 400; i++) begin
            @(negedge ref_clk);
            if ((s == 0 ? copper_enable : s == 1 ? fiber_enable : copper_power_up) === v) begin
                @(posedge ref_clk);
                return;
            end
        end
        bail();
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        apb(8'h00, 1'b0, 32'h0, 33'h8000);
        apb(8'h04, 1'b0, 32'h0, 33'h004c);
        apb(8'h10, 1'b0, 32'h0, 33'h100000000);
        res <= 5'($random(seed));
        cu_plug <= 1'b1;
        await(0, 1'b1);
        apb(8'h08, 1'b0, 32'h0, {17'h0, res[4:3], res[2], 3'b000, res[1:0], 8'h08},
            32'he398);
        fi_plug <= 1'b1;
        repeat (12) @(posedge ref_clk);
        `CHK("fiber_power", 1'b0, fiber_power_up)
        apb(8'h00, 1'b1, 32'h0001);
        apb(8'h0c, 1'b0, 32'h0, 33'h10);
        apb(8'h0c, 1'b1, 32'h10);
        apb(8'h0c, 1'b0, 32'h0, 33'h00);
        apb(8'h08, 1'b0, 32'h0, 33'h08, 32'h88);
        apb(8'h00, 1'b1, 32'h8000);
        cu_plug <= 1'b0;
        await(1, 1'b1);
        apb(8'h00, 1'b0, 32'h0, 33'h8001);
        apb(8'h08, 1'b0, 32'h0, 33'h88, 32'h88);
        apb(8'h04, 1'b1, 32'h804e);
        await(1, 1'b1);
        res <= 5'($random(seed));
        cu_plug <= 1'b1;
        await(1, 1'b0);
        await(0, 1'b1);
        apb(8'h04, 1'b0, 32'h0, 33'h004e);
        apb(8'h00, 1'b1, 32'h0001);
        apb(8'h08, 1'b0, 32'h0, 33'h00, 32'h10);
        apb(8'h04, 1'b1, 32'h804d);
        await(1, 1'b1);
        apb(8'h00, 1'b1, 32'h0000);
        apb(8'h08, 1'b0, 32'h0, 33'h10, 32'h10);
        restart <= 1'b1;
        await(0, 1'b1);
        await(0, 1'b0);
        // Copper stays dark for the whole drop interval
        for (n = 0; n < 1000 && copper_power_up !== 1'b1; n++) @(negedge ref_clk);
        `CHK("drop_len", 1'b1, n >= DROP - 1 && n <= DROP + 2)
        @(posedge ref_clk);
        cu_plug <= 1'b0;
        fi_plug <= 1'b0;
        restart <= 1'b0;
        apb(8'h04, 1'b1, 32'h804c);
        cu_plug <= 1'b1;
        fi_plug <= 1'b1;
        await(0, 1'b1);
        `CHK("tie", 1'b0, fiber_enable)
        cu_plug <= 1'b0;
        fi_plug <= 1'b0;
        apb(8'h04, 1'b1, 32'h8068);
        pol <= 1'b1;
        fi_plug <= 1'b1;
        repeat (30) @(posedge ref_clk);
        `CHK("sgmii_down", 1'b0, fiber_enable)
        sg_link <= 1'b1;
        await(1, 1'b1);
        sg_link <= 1'b0;
        apb(8'h04, 1'b1, 32'h802c);
        await(1, 1'b1);
        fi_plug <= 1'b0;
        await(1, 1'b0);
        tally_and_finish();
    end
endmodule // media_select_tb
`default_nettype wire
